// ===== verilog/lcm_pkg.sv
// Constants and types for the ladder code mapper
//
// How it works
// - The hold byte is an 8-bit two's-complement sample in both modes.
// - Output is a 10-bit ladder code, zero lowest, all ones highest.
// - Full scale: inverted sign, hold bits 6..0, control bits 5..4.
// - Full scale spans -512..+511; 80H/00 gives 000H, 00H/00 gives 200H.
// - Half scale: inverted sign, whole hold byte, control bit 5; bit 4 ignored.
// - Half scale spans -256..+255, codes 100H to 2FFH.
// - Control bit 3 set selects half scale, clear selects full scale.
`default_nettype none

package lcm_pkg;

    // Register indices; byte address is four times the index
    localparam logic [7:0]  LCM_IDX_ANALOG_CONTROL = 8'hef;
    localparam logic [7:0]  LCM_IDX_HOLD_BYTE      = 8'hfa;
    localparam logic [7:0]  LCM_IDX_CODE_STATUS    = 8'hf1;
    localparam int          LCM_ADDR_W             = 12;
    localparam logic [11:0] LCM_ADDR_ANALOG_CONTROL = {2'h0, LCM_IDX_ANALOG_CONTROL, 2'h0};
    localparam logic [11:0] LCM_ADDR_HOLD_BYTE      = {2'h0, LCM_IDX_HOLD_BYTE, 2'h0};
    localparam logic [11:0] LCM_ADDR_CODE_STATUS    = {2'h0, LCM_IDX_CODE_STATUS, 2'h0};

    // Field positions in the analog control register
    localparam int LCM_CTL_GUARD_BIT = 7;
    localparam int LCM_CTL_HALF_BIT  = 3;

    // Widths and reset values
    localparam int         LCM_CODE_W        = 10;
    localparam logic [7:0] LCM_HOLD_RESET    = 8'h80;
    localparam logic [6:0] LCM_CTL_RESET     = 7'h00;
    localparam logic [9:0] LCM_CODE_RESET    = 10'h000;

    // Analog control register layout
    typedef struct packed {
        logic guard_n;
        logic spare;
        logic low_code_bit_high;
        logic low_code_bit_low;
        logic half_swing_select;
        logic power_sel;
        logic aux_sel;
        logic front_end_on;
    } lcm_ctl_s;

    typedef logic [LCM_CODE_W-1:0] lcm_code_t;

endpackage : lcm_pkg

`default_nettype wire

// ===== verilog/lcm_top.sv
// Ladder code mapper: APB registers and 10-bit ladder code generation
//
// Chosen here: the APB interface to the registers.
`default_nettype none

module lcm_top (
    // Clock and reset
    input  wire logic              pclk,
    input  wire logic              presetn,
    // APB slave
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [11:0]       paddr,
    input  wire logic [31:0]       pwdata,
    input  wire logic [3:0]        pstrb,
    output logic                   pready,
    output logic      [31:0]       prdata,
    output logic                   pslverr,
    // Ladder side
    output lcm_pkg::lcm_code_t     ladder_code,
    output lcm_pkg::lcm_ctl_s      analog_control
);
    import lcm_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Bus decode

    logic setup_phase;
    logic access_phase;
    logic hit_ctl;
    logic hit_hold;
    logic hit_status;
    logic hit_any;
    logic wr_ctl;
    logic wr_hold;

    always_comb begin
        setup_phase  = psel & ~penable;
        access_phase = psel & penable;
        hit_ctl      = (paddr == LCM_ADDR_ANALOG_CONTROL);
        hit_hold     = (paddr == LCM_ADDR_HOLD_BYTE);
        hit_status   = (paddr == LCM_ADDR_CODE_STATUS);
        hit_any      = hit_ctl | hit_hold | hit_status;
        wr_ctl       = access_phase & pwrite & hit_ctl & pstrb[0];
        wr_hold      = access_phase & pwrite & hit_hold & pstrb[0];
    end

    ////////////////////////////////////////////////////////////////////////
    // Registers

    logic [7:0] hold_q;
    logic [7:0] hold_d;
    logic [6:0] ctl_q;
    logic [6:0] ctl_d;
    logic       guard_ok;

    always_comb begin
        hold_d   = hold_q;
        ctl_d    = ctl_q;
        // Guard low in the written value opens the control bits
        guard_ok = ~pwdata[LCM_CTL_GUARD_BIT];
        if (wr_hold) begin
            hold_d = pwdata[7:0];
        end
        if (wr_ctl && guard_ok) begin
            ctl_d = pwdata[6:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hold_q <= LCM_HOLD_RESET;
            ctl_q  <= LCM_CTL_RESET;
        end else begin
            hold_q <= hold_d;
            ctl_q  <= ctl_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Ladder code mapping

    lcm_ctl_s  ctl_view;
    lcm_code_t code_d;
    lcm_code_t code_q;

    always_comb begin
        ctl_view = lcm_ctl_s'({1'b0, ctl_q});
        if (ctl_view.half_swing_select) begin
            // Sign inverted, full byte in the middle, one low bit
            code_d = {~hold_q[7], hold_q, ctl_view.low_code_bit_high};
        end else begin
            code_d = {~hold_q[7], hold_q[6:0], ctl_view.low_code_bit_high,
                      ctl_view.low_code_bit_low};
        end
    end

    // Code follows the registers one edge later
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            code_q <= LCM_CODE_RESET;
        end else begin
            code_q <= code_d;
        end
    end

    assign ladder_code    = code_q;
    assign analog_control = ctl_view;

    ////////////////////////////////////////////////////////////////////////
    // Read data, captured in the setup cycle

    logic [31:0] rdata_d;
    logic [31:0] rdata_q;
    logic        err_d;
    logic        err_q;

    always_comb begin
        rdata_d = rdata_q;
        err_d   = err_q;
        if (setup_phase) begin
            err_d   = ~hit_any;
            rdata_d = 32'h0000_0000;
            if (hit_ctl) begin
                rdata_d = {25'h0, ctl_q};
            end
            if (hit_hold) begin
                rdata_d = {24'h0, hold_q};
            end
            if (hit_status) begin
                rdata_d = {22'h0, code_q};
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rdata_q <= 32'h0000_0000;
            err_q   <= 1'b0;
        end else begin
            rdata_q <= rdata_d;
            err_q   <= err_d;
        end
    end

    assign pready  = 1'b1;
    assign prdata  = (access_phase & ~pwrite) ? rdata_q : 32'h0000_0000;
    assign pslverr = access_phase & err_q;

    ////////////////////////////////////////////////////////////////////////
    // Checks

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    a_full_map_form: assert property (
        !ctl_q[LCM_CTL_HALF_BIT] |=> code_q == {~$past(hold_q[7]), $past(hold_q[6:0]), $past(ctl_q[5:4])})
        else $error("Full-scale code mismatch");

    a_half_map_form: assert property (
        ctl_q[LCM_CTL_HALF_BIT] |=> code_q == {~$past(hold_q[7]), $past(hold_q), $past(ctl_q[5])})
        else $error("Half-scale code mismatch");

    a_half_code_range: assert property (
        ctl_q[LCM_CTL_HALF_BIT] |=> (code_q >= 10'h100) && (code_q <= 10'h2ff))
        else $error("Half-scale code out of range");

    a_full_min_point: assert property (
        (hold_q == 8'h80) && (ctl_q[5:4] == 2'b00) && !ctl_q[3] |=> code_q == 10'h000)
        else $error("Full-scale minimum not 000H");

    a_full_mid_point: assert property (
        (hold_q == 8'h00) && (ctl_q[5:4] == 2'b00) && !ctl_q[3] |=> code_q == 10'h200)
        else $error("Full-scale midscale not 200H");

    a_signed_order: assert property (
        $stable(ctl_q) && $signed(hold_q) > $signed($past(hold_q))
        |=> code_q > $past(code_q))
        else $error("Code not monotonic in signed sample");

    a_code_write_lag: assert property (
        wr_hold ##1 1'b1 |=> ($past(ctl_q[3]) ? code_q[8:1] == $past(hold_q)
                                              : code_q[8:2] == $past(hold_q[6:0])))
        else $error("Code not updated after write");

    a_half_bit4_void: assert property (
        ctl_q[3] && $stable(ctl_q[3]) && $stable(ctl_q[5]) && $stable(hold_q)
        |=> $stable(code_q))
        else $error("Control bit 4 leaks in half scale");

    a_mode_select: assert property (
        wr_ctl && !pwdata[7] |=> ctl_q[3] == $past(pwdata[3]))
        else $error("Half-swing select not stored");

    a_guard_blocks: assert property (
        wr_ctl && pwdata[7] |=> $stable(ctl_q))
        else $error("Guarded write changed control");

    a_code_width: assert property (
        (hold_q == 8'h7f) && (ctl_q[5:4] == 2'b11) && !ctl_q[3] |=> code_q == 10'h3ff)
        else $error("Full-scale top not 3FFH");

    a_full_bit4_used: assert property (
        !ctl_q[3] && $stable(ctl_q[3]) && $stable(hold_q) && $changed(ctl_q[4]) |=> $changed(code_q))
        else $error("Control bit 4 ignored in full scale");

    a_full_low_bits: assert property (
        !ctl_q[3] |=> code_q[1:0] == $past(ctl_q[5:4]))
        else $error("Full-scale low bits wrong");

    a_full_sign_flip: assert property (
        !ctl_q[3] |=> code_q[9] == !$past(hold_q[7]))
        else $error("Full-scale top bit not inverted sign");

    a_full_signed_span: assert property (
        !ctl_q[3] |=> int'(code_q) ==
            32'sh200 + 32'sh4 * int'($signed($past(hold_q))) + int'($past(ctl_q[5:4])))
        else $error("Full-scale value off its signed span");

    a_full_minus_one: assert property (
        (hold_q == 8'hff) && (ctl_q[5:4] == 2'b11) && !ctl_q[3] |=> code_q == 10'h1ff)
        else $error("Full-scale minus one not 1FFH");

    ////////////////////////////////////////////////////////////////////////
    // Checks: half-scale mapping

    a_half_sign_flip: assert property (
        ctl_q[3] |=> code_q[9] == !$past(hold_q[7]))
        else $error("Half-scale top bit not inverted sign");

    a_half_low_bit: assert property (
        ctl_q[3] |=> code_q[0] == $past(ctl_q[5]))
        else $error("Half-scale low bit not control bit 5");

    a_half_signed_span: assert property (
        ctl_q[3] |=> int'(code_q) ==
            32'sh200 + 32'sh2 * int'($signed($past(hold_q))) + int'($past(ctl_q[5])))
        else $error("Half-scale value off its signed span");

    a_half_sign_ext: assert property (
        ctl_q[3] |=> code_q[9] != code_q[8])
        else $error("Half-scale code not sign extended");

    a_half_bottom: assert property (
        (hold_q == 8'h80) && !ctl_q[5] && ctl_q[3] |=> code_q == 10'h100)
        else $error("Half-scale minimum not 100H");

    a_half_mid_point: assert property (
        (hold_q == 8'h00) && !ctl_q[5] && ctl_q[3] |=> code_q == 10'h200)
        else $error("Half-scale midscale not 200H");

    a_half_top_point: assert property (
        (hold_q == 8'h7f) && ctl_q[5] && ctl_q[3] |=> code_q == 10'h2ff)
        else $error("Half-scale top not 2FFH");

    a_half_minus_one: assert property (
        (hold_q == 8'hff) && ctl_q[5] && ctl_q[3] |=> code_q == 10'h1ff)
        else $error("Half-scale minus one not 1FFH");

    ////////////////////////////////////////////////////////////////////////
    // Checks: register and code updates

    a_hold_store: assert property (
        wr_hold |=> hold_q == $past(pwdata[7:0]))
        else $error("Hold byte write not stored");

    a_ctl_store: assert property (
        wr_ctl && !pwdata[LCM_CTL_GUARD_BIT] |=> ctl_q == $past(pwdata[6:0]))
        else $error("Control write not stored");

    a_hold_no_stray: assert property (
        !wr_hold |=> $stable(hold_q))
        else $error("Hold byte changed without a write");

    a_ctl_no_stray: assert property (
        !(wr_ctl && !pwdata[LCM_CTL_GUARD_BIT]) |=> $stable(ctl_q))
        else $error("Control changed without an open write");

    a_code_still: assert property (
        $stable(hold_q) && $stable(ctl_q) |=> $stable(code_q))
        else $error("Code moved with registers still");

    a_code_follows: assert property (
        $changed(hold_q) |=> $changed(code_q))
        else $error("Code did not follow a new sample");

    ////////////////////////////////////////////////////////////////////////
    // Checks: read-back

    a_hold_readback: assert property (
        setup_phase && !pwrite && hit_hold ##1 access_phase |-> prdata == {24'h0, $past(hold_q)})
        else $error("Hold byte read-back wrong");

    a_ctl_readback: assert property (
        setup_phase && !pwrite && hit_ctl ##1 access_phase |-> prdata == {25'h0, $past(ctl_q)})
        else $error("Control read-back wrong");

    a_status_readback: assert property (
        setup_phase && !pwrite && hit_status ##1 access_phase |-> prdata == {22'h0, $past(code_q)})
        else $error("Code status read-back wrong");

    ////////////////////////////////////////////////////////////////////////
    // Coverage

    c_full_mode: cover property (!ctl_q[3] ##1 code_q == 10'h3ff);
    c_half_mode: cover property (ctl_q[3] ##1 code_q == 10'h100);
    c_mode_swap: cover property (wr_ctl && !pwdata[LCM_CTL_GUARD_BIT] && (pwdata[3] != ctl_q[3]));
    c_bad_addr:  cover property (pslverr);
    c_half_bit4: cover property (ctl_q[3] && $changed(ctl_q[4]));

endmodule // lcm_top

`default_nettype wire

// ===== bench/lcm_ladder_model.sv
// Behavioural model of the resistor ladder: code to output level in millivolts
`default_nettype none

module lcm_ladder_model #(
    parameter int VDD_MV = 3000
) (
    // Ladder code from the mapper
    input  wire lcm_pkg::lcm_code_t code,
    // Output level
    output var  int                 level_mv
);
    timeunit 1ns;
    timeprecision 1ps;
    import lcm_pkg::*;

    // Code zero is ground, all ones one step below supply
    assign level_mv = (int'(code) * VDD_MV) / 1024;
endmodule // lcm_ladder_model

`default_nettype wire

// ===== bench/tb.sv
// Testbench for the ladder code mapper
`default_nettype none

module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import lcm_pkg::*;

    logic        pclk       = 1'b0;
    logic        presetn    = 1'b0;
    logic        psel       = 1'b0;
    logic        penable    = 1'b0;
    logic        pwrite     = 1'b0;
    logic [11:0] paddr      = 12'h000;
    logic [31:0] pwdata     = 32'h0;
    logic [3:0]  pstrb      = 4'hf;
    logic        pready;
    logic [31:0] prdata;
    logic        pslverr;
    lcm_code_t   ladder_code;
    lcm_ctl_s    analog_control;
    int          level_mv;
    int          failures   = 0;
    int          num_checks = 0;
    logic [31:0] rdat;
    logic        err;
    logic [7:0]  hv_tab [6] = '{8'h80, 8'h80, 8'h81, 8'hff, 8'h00, 8'h7f};
    logic [1:0]  lb_tab [6] = '{2'h0, 2'h1, 2'h0, 2'h3, 2'h2, 2'h3};

    lcm_top dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
                 .pready, .prdata, .pslverr, .ladder_code, .analog_control);
    lcm_ladder_model ladder (.code(ladder_code), .level_mv(level_mv));

    always #2 pclk = ~pclk;

    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            failures++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic end_sim();
        $display("Checks %0d, mismatches %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // One APB transfer; leaves an idle cycle before the next setup
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) begin
            failures++;
            end_sim();
        end
        rdat = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(rdat, exp);
    endtask

    // Load hold byte and control, then check the code two edges later
    task automatic set(input logic [7:0] h, input logic [7:0] c, input logic [9:0] e);
        apb(1'b1, LCM_ADDR_HOLD_BYTE, {24'h0, h});
        apb(1'b1, LCM_ADDR_ANALOG_CONTROL, {24'h0, c});
        repeat (2) @(posedge pclk);
        chk({22'h0, ladder_code}, {22'h0, e});
        chk({24'h0, analog_control}, {24'h0, c & 8'h7f});
    endtask

    function automatic logic [9:0] exp_code(input logic [7:0] h, input logic [7:0] c);
        if (c[3]) begin
            return {~h[7], h, c[5]};
        end
        return {~h[7], h[6:0], c[5:4]};
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        chk({22'h0, ladder_code}, 32'h0);
        rd(LCM_ADDR_HOLD_BYTE, 32'h80);
        rd(LCM_ADDR_ANALOG_CONTROL, 32'h0);
        set(8'h80, 8'h00, 10'h000);
        chk(level_mv, 0);
        set(8'h00, 8'h00, 10'h200);
        chk(level_mv, 1500);
        set(8'h7f, 8'h30, 10'h3ff);
        chk(level_mv, 2997);
        rd(LCM_ADDR_CODE_STATUS, 32'h3ff);
        set(8'h80, 8'h08, 10'h100);
        set(8'h7f, 8'h38, 10'h2ff);
        chk(level_mv, 2247);
        set(8'h00, 8'h18, 10'h200);
        set(8'h81, 8'h28, 10'h103);
        for (int i = 0; i < 12; i++) begin
            set(hv_tab[i % 6], {2'b00, lb_tab[i % 6], i >= 6, 3'b000},
                exp_code(hv_tab[i % 6], {2'b00, lb_tab[i % 6], i >= 6, 3'b000}));
        end
        set(8'h00, 8'h04, 10'h200);
        apb(1'b1, LCM_ADDR_ANALOG_CONTROL, 32'h88);
        repeat (2) @(posedge pclk);
        chk({22'h0, ladder_code}, 32'h200);
        rd(LCM_ADDR_ANALOG_CONTROL, 32'h04);
        apb(1'b0, 12'h004, 32'h0);
        chk({31'h0, err}, 32'h1);
        chk(rdat, 32'h0);
        set(8'h80, 8'h00, 10'h000);
        set(8'h7f, 8'h30, 10'h3ff);
        presetn <= 1'b0;
        repeat (3) @(posedge pclk);
        chk({22'h0, ladder_code}, 32'h0);
        presetn <= 1'b1;
        rd(LCM_ADDR_HOLD_BYTE, 32'h80);
        end_sim();
    end
endmodule // tb

`default_nettype wire
